// ### rtl/gpio_interrupt_debounce.sv
// Interrupt status, trigger, latch, clear and switch debounce logic of the I/O expander.
`timescale 1ns/1ps
`include "gpio_irq_defines.svh"
module gpio_interrupt_debounce (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sw_reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire gpio_irq_pkg::pin_vec_t pin_in,
  output logic int_out,
  output logic int_oe_n
);
  import gpio_irq_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pin_vec_t sync1_ff;
  pin_vec_t sync2_ff;
  logic tb_prev_ff;
  logic tick;
  pin_vec_t cfg_ff;
  pin_vec_t latch_ff;
  pin_vec_t mask_ff;
  logic [8*`EDGE_BYTES-1:0] edge_ff;
  logic [15:0] db_en_ff;
  db_count_t db_count_ff;
  logic db_on;
  pin_vec_t db_out;
  pin_vec_t eff;
  pin_vec_t prev_eff_ff;
  pin_vec_t ref_ff;
  pin_vec_t hold_ff;
  pin_vec_t status_ff;
  pin_vec_t nxt_status;
  pin_vec_t set_ev;
  pin_vec_t set_eff;
  pin_vec_t lvl_nl;
  pin_vec_t mode_clr;
  pin_vec_t clr_wr;
  pin_vec_t rd_port;
  pin_vec_t clr_any;
  pin_vec_t active;
  pin_vec_t port_val;
  logic [1:0] init_cnt_ff;
  logic init_pend;
  logic int_oe_n_ff;
  logic [7:0] rdata_ff;
  logic [7:0] rd_mux;

  assign int_out = 1'b0;
  assign int_oe_n = int_oe_n_ff;
  assign reg_rdata = rdata_ff;
  assign init_pend = (init_cnt_ff != 2'h0);

  // ****************************************************************
  // Pin synchronisers and time base
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tb_prev_ff <= 1'b0;
    end else begin
      tb_prev_ff <= sync2_ff[0];
    end
  end

  assign tick = sync2_ff[0] & ~tb_prev_ff;

  // Synchronised pins settle a few cycles after release, so triggers wait for that.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      init_cnt_ff <= `INIT_CYCLES;
    end else if (sw_reset) begin
      init_cnt_ff <= `INIT_CYCLES;
    end else if (init_pend) begin
      init_cnt_ff <= init_cnt_ff - 2'h1;
    end
  end

  // ****************************************************************
  // Per-port registers
  // ****************************************************************
  genvar gp;
  for (gp = 0; gp < `PORT_COUNT; gp++) begin : g_port
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        cfg_ff[8*gp +: 8] <= `CFG_RST;
      end else if (sw_reset) begin
        cfg_ff[8*gp +: 8] <= `CFG_RST;
      end else if (reg_wr && (reg_addr == 8'(`ADDR_CFG0 + gp))) begin
        cfg_ff[8*gp +: 8] <= reg_wdata;
      end
    end

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        latch_ff[8*gp +: 8] <= `LATCH_RST;
      end else if (sw_reset) begin
        latch_ff[8*gp +: 8] <= `LATCH_RST;
      end else if (reg_wr && (reg_addr == 8'(`ADDR_LATCH0 + gp))) begin
        latch_ff[8*gp +: 8] <= reg_wdata;
      end
    end

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        mask_ff[8*gp +: 8] <= `MASK_RST;
      end else if (sw_reset) begin
        mask_ff[8*gp +: 8] <= `MASK_RST;
      end else if (reg_wr && (reg_addr == 8'(`ADDR_MASK0 + gp))) begin
        mask_ff[8*gp +: 8] <= reg_wdata;
      end
    end

    // Clear bits are never stored, so they read back as zero.
    assign clr_wr[8*gp +: 8] = (reg_wr && (reg_addr == 8'(`ADDR_CLEAR0 + gp))) ?
                               reg_wdata : 8'h00;
    assign rd_port[8*gp +: 8] = {8{reg_rd && (reg_addr == 8'(`ADDR_INPUT0 + gp))}};
  end

  genvar ge;
  for (ge = 0; ge < `EDGE_BYTES; ge++) begin : g_edge
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        edge_ff[8*ge +: 8] <= `EDGE_RST;
      end else if (sw_reset) begin
        edge_ff[8*ge +: 8] <= `EDGE_RST;
      end else if (reg_wr && (reg_addr == 8'(`ADDR_EDGE0 + ge))) begin
        edge_ff[8*ge +: 8] <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Debounce configuration
  // ****************************************************************
  // The count is taken as written; software arms the time base before it.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      db_en_ff <= {`DB_EN_RST, `DB_EN_RST};
      db_count_ff <= `DB_COUNT_RST;
    end else if (sw_reset) begin
      db_en_ff <= {`DB_EN_RST, `DB_EN_RST};
      db_count_ff <= `DB_COUNT_RST;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_DB_EN0) begin
        db_en_ff[7:0] <= reg_wdata;
      end
      if (reg_addr == (`ADDR_DB_EN0 + 8'h01)) begin
        db_en_ff[15:8] <= reg_wdata;
      end
      if (reg_addr == `ADDR_DB_COUNT) begin
        db_count_ff <= reg_wdata;
      end
    end
  end

  assign db_on = (db_count_ff != 8'h00) && cfg_ff[0] && db_en_ff[0];

  // ****************************************************************
  // Per-pin debounce and trigger logic
  // ****************************************************************
  genvar gk;
  for (gk = 0; gk < `PIN_COUNT; gk++) begin : g_pin
    localparam int EB = gk / 4;
    localparam int EO = 2 * (gk % 4);
    trig_mode_t mode;
    assign mode = trig_mode_t'(edge_ff[2*gk +: 2]);

    if ((gk >= `DB_PIN_LO) && (gk <= `DB_PIN_HI)) begin : g_db
      logic use_db;
      assign use_db = db_on && db_en_ff[gk] && cfg_ff[gk];
      // Each debounced pin (1 to 15) owns its counter; tick and count are common to all.
      pin_debouncer u_db (
        .core_clk(core_clk),
        .reset(reset),
        .clr(sw_reset),
        .en(use_db),
        .tick(tick),
        .sample(sync2_ff[gk]),
        .count(db_count_ff),
        .level_out(db_out[gk])
      );
      assign eff[gk] = use_db ? db_out[gk] : sync2_ff[gk];
    end else begin : g_raw
      assign db_out[gk] = sync2_ff[gk];
      assign eff[gk] = sync2_ff[gk];
    end

    always_comb begin
      case (mode)
        TRIG_LEVEL: set_ev[gk] = eff[gk] ^ ref_ff[gk];
        TRIG_RISE: set_ev[gk] = eff[gk] & ~prev_eff_ff[gk];
        TRIG_FALL: set_ev[gk] = ~eff[gk] & prev_eff_ff[gk];
        TRIG_ANY: set_ev[gk] = eff[gk] ^ prev_eff_ff[gk];
        default: set_ev[gk] = 1'b0;
      endcase
      set_ev[gk] = set_ev[gk] & active[gk] & ~init_pend;
    end

    assign lvl_nl[gk] = (mode == TRIG_LEVEL) && !latch_ff[gk];
    assign mode_clr[gk] = reg_wr && (reg_addr == 8'(`ADDR_EDGE0 + EB)) &&
      ((mode == TRIG_LEVEL) != (reg_wdata[EO +: 2] == TRIG_LEVEL));
    // A level mismatch is a standing condition, not an event, so it must not
    // outvote the mode-change clear or the status would never drop.
    assign set_eff[gk] = set_ev[gk] & ~(mode_clr[gk] & (mode == TRIG_LEVEL));
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // A pin taken to output loses its source; taken back to input, a level
  // mismatch against the reference raises the interrupt at once.
  assign active = cfg_ff & ~mask_ff;
  assign clr_any = clr_wr | rd_port | mode_clr;

  // Set wins over every clear except a level pin's mode-change clear; level non-latched pins simply follow the mismatch.
  assign nxt_status = ((lvl_nl & set_eff) | (~lvl_nl & ((status_ff & ~clr_any) | set_eff)))
                      & active;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_ff <= '0;
    end else if (sw_reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_oe_n_ff <= 1'b1;
    end else if (sw_reset) begin
      int_oe_n_ff <= 1'b1;
    end else begin
      int_oe_n_ff <= ~(|nxt_status);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_eff_ff <= '0;
    end else begin
      prev_eff_ff <= eff;
    end
  end

  // The reference is what software last saw; reading a port refreshes it.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_ff <= '0;
    end else if (init_pend || sw_reset) begin
      ref_ff <= eff;
    end else begin
      ref_ff <= (ref_ff & ~rd_port) | (eff & rd_port);
    end
  end

  // A latched pin keeps the value that raised its interrupt until serviced.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= (hold_ff & ~(set_ev & ~status_ff & latch_ff)) |
                 (eff & set_ev & ~status_ff & latch_ff);
    end
  end

  assign port_val = (latch_ff & status_ff & hold_ff) | (~(latch_ff & status_ff) & eff);

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  always_comb begin
    case (reg_addr)
      `ADDR_INPUT0: rd_mux = port_val[7:0];
      `ADDR_INPUT0 + 8'h01: rd_mux = port_val[15:8];
      `ADDR_INPUT0 + 8'h02: rd_mux = port_val[23:16];
      `ADDR_CFG0: rd_mux = cfg_ff[7:0];
      `ADDR_CFG0 + 8'h01: rd_mux = cfg_ff[15:8];
      `ADDR_CFG0 + 8'h02: rd_mux = cfg_ff[23:16];
      `ADDR_LATCH0: rd_mux = latch_ff[7:0];
      `ADDR_LATCH0 + 8'h01: rd_mux = latch_ff[15:8];
      `ADDR_LATCH0 + 8'h02: rd_mux = latch_ff[23:16];
      `ADDR_MASK0: rd_mux = mask_ff[7:0];
      `ADDR_MASK0 + 8'h01: rd_mux = mask_ff[15:8];
      `ADDR_MASK0 + 8'h02: rd_mux = mask_ff[23:16];
      `ADDR_EDGE0: rd_mux = edge_ff[7:0];
      `ADDR_EDGE0 + 8'h01: rd_mux = edge_ff[15:8];
      `ADDR_EDGE0 + 8'h02: rd_mux = edge_ff[23:16];
      `ADDR_EDGE0 + 8'h03: rd_mux = edge_ff[31:24];
      `ADDR_EDGE0 + 8'h04: rd_mux = edge_ff[39:32];
      `ADDR_EDGE0 + 8'h05: rd_mux = edge_ff[47:40];
      `ADDR_INSTAT0: rd_mux = eff[7:0];
      `ADDR_INSTAT0 + 8'h01: rd_mux = eff[15:8];
      `ADDR_INSTAT0 + 8'h02: rd_mux = eff[23:16];
      `ADDR_DB_EN0: rd_mux = db_en_ff[7:0];
      `ADDR_DB_EN0 + 8'h01: rd_mux = db_en_ff[15:8];
      `ADDR_DB_COUNT: rd_mux = db_count_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_int_follows_status;
    @(posedge core_clk) disable iff (reset)
    int_oe_n_ff == !(|status_ff);
  endproperty
  a_int_follows_status: assert property (p_int_follows_status)
    else $error("Interrupt output disagrees with pending status.");

  property p_output_pin_quiet;
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> ((status_ff & ~$past(cfg_ff)) == '0);
  endproperty
  a_output_pin_quiet: assert property (p_output_pin_quiet)
    else $error("Status pending on a pin configured as output.");

  property p_masked_pin_quiet;
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> ((status_ff & $past(mask_ff)) == '0);
  endproperty
  a_masked_pin_quiet: assert property (p_masked_pin_quiet)
    else $error("Status pending on a masked pin.");

  property p_read_clears_port0;
    @(posedge core_clk) disable iff (reset)
    (reg_rd && (reg_addr == `ADDR_INPUT0) && !sw_reset && !(|set_ev[7:0]))
      |=> (status_ff[7:0] == 8'h00);
  endproperty
  a_read_clears_port0: assert property (p_read_clears_port0)
    else $error("Input port read left port 0 status pending.");

  property p_clear_write;
    @(posedge core_clk) disable iff (reset)
    (reg_wr && (reg_addr == `ADDR_CLEAR0))
      |=> ((status_ff[7:0] & $past(reg_wdata) & ~$past(set_ev[7:0])) == 8'h00);
  endproperty
  a_clear_write: assert property (p_clear_write)
    else $error("Clear write left a status bit pending.");

  property p_level_self_clear;
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> ((status_ff & $past(lvl_nl & ~(eff ^ ref_ff))) == '0);
  endproperty
  a_level_self_clear: assert property (p_level_self_clear)
    else $error("Level non-latched status stayed after pin returned.");

  property p_mode_change_clear;
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> ((status_ff & $past(mode_clr & ~set_eff)) == '0);
  endproperty
  a_mode_change_clear: assert property (p_mode_change_clear)
    else $error("Trigger mode change left status pending.");

  property p_zero_count_bypass;
    @(posedge core_clk) disable iff (reset)
    (db_count_ff == 8'h00) |-> (eff == sync2_ff);
  endproperty
  a_zero_count_bypass: assert property (p_zero_count_bypass)
    else $error("Debounce active with zero count.");

  property p_soft_reset_release;
    @(posedge core_clk) disable iff (reset)
    sw_reset |=> (int_oe_n_ff && (status_ff == '0));
  endproperty
  a_soft_reset_release: assert property (p_soft_reset_release)
    else $error("Software reset did not release the interrupt.");
endmodule : gpio_interrupt_debounce

// ### rtl/gpio_irq_defines.svh
// Register offsets, reset values and counts of the interrupt and debounce block.
`ifndef GPIO_IRQ_DEFINES_SVH
`define GPIO_IRQ_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PIN_COUNT 24
`define PORT_COUNT 3
`define EDGE_BYTES 6
`define DEBOUNCE_CNT_W 8
`define DB_PIN_LO 1
`define DB_PIN_HI 15
`define INIT_CYCLES 2'h3

// ****************************************************************
// Register offsets (first register of each group)
// ****************************************************************
`define ADDR_INPUT0 8'h00
`define ADDR_CFG0 8'h0C
`define ADDR_LATCH0 8'h48
`define ADDR_MASK0 8'h54
`define ADDR_EDGE0 8'h60
`define ADDR_CLEAR0 8'h68
`define ADDR_INSTAT0 8'h6C
`define ADDR_DB_EN0 8'h74
`define ADDR_DB_COUNT 8'h76

// ****************************************************************
// Reset values
// ****************************************************************
`define CFG_RST 8'hFF
`define LATCH_RST 8'h00
`define MASK_RST 8'hFF
`define EDGE_RST 8'h00
`define DB_EN_RST 8'h00
`define DB_COUNT_RST 8'h00

`endif

// ### rtl/gpio_irq_pkg.sv
// Types shared by the interrupt and debounce logic.
`include "gpio_irq_defines.svh"
package gpio_irq_pkg;
  typedef logic [`PIN_COUNT-1:0] pin_vec_t;
  typedef logic [`DEBOUNCE_CNT_W-1:0] db_count_t;
  typedef enum logic [1:0] {
    TRIG_LEVEL = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_ANY = 2'h3
  } trig_mode_t;
endpackage : gpio_irq_pkg

// ### rtl/pin_debouncer.sv
// One switch debouncer, stepped by the shared time-base tick.
`timescale 1ns/1ps
`include "gpio_irq_defines.svh"
module pin_debouncer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clr,
  input wire logic en,
  input wire logic tick,
  input wire logic sample,
  input wire gpio_irq_pkg::db_count_t count,
  output logic level_out
);
  import gpio_irq_pkg::*;

  db_count_t cnt_ff;
  db_count_t nxt_cnt;
  logic stable_ff;

  assign nxt_cnt = cnt_ff + 8'h01;
  assign level_out = stable_ff;

  // ****************************************************************
  // Qualification counter
  // ****************************************************************
  // While disabled the output tracks the pin so that enabling starts clean.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stable_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (clr || !en) begin
      stable_ff <= sample;
      cnt_ff <= 8'h00;
    end else if (tick) begin
      if (sample == stable_ff) begin
        cnt_ff <= 8'h00;
      end else if (nxt_cnt == count) begin
        stable_ff <= sample;
        cnt_ff <= 8'h00;
      end else begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  property p_hold_between_ticks;
    @(posedge core_clk) disable iff (reset)
    (en && !clr && !tick) |=> (stable_ff == $past(stable_ff));
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks)
    else $error("Debounced level moved without a time-base tick.");

  property p_flip_only_at_count;
    @(posedge core_clk) disable iff (reset)
    (en && !clr && tick && (sample != stable_ff) && (nxt_cnt != count))
      |=> (stable_ff == $past(stable_ff)) && (cnt_ff == $past(nxt_cnt));
  endproperty
  a_flip_only_at_count: assert property (p_flip_only_at_count)
    else $error("Debounced level changed before the count was reached.");
endmodule : pin_debouncer

// ### test/mcu_model.sv
// Model of the system microcontroller issuing single-byte register accesses.
`timescale 1ns/1ps
module mcu_model (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Idle address and data are inverted so that a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : mcu_model

// ### test/tb.sv
// Self-checking bench for the interrupt and debounce block.
`timescale 1ns/1ps
module tb;
  import gpio_irq_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic sw_reset = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rd_val;
  logic [7:0] rnd;
  pin_vec_t pin_in = 24'h000000;
  logic int_out;
  logic int_oe_n;
  int mismatches = 0;
  int n_tests = 0;
  integer seed = 32'hD5D11E1E;

  always #12.5 core_clk = ~core_clk;

  gpio_interrupt_debounce dut (.core_clk(core_clk), .reset(reset), .sw_reset(sw_reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .int_out(int_out), .int_oe_n(int_oe_n));
  mcu_model mcu (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  function automatic logic hit(input int m, input int o, input int n);
    if (o == n) begin
      return 1'b0;
    end
    return (m == 0) || (m == 1 && n == 1) || (m == 2 && n == 0) || (m == 3);
  endfunction : hit

  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : idle

  // Port 2 pins stay masked, so they carry random noise throughout.
  task automatic pin_set(input int k, input logic v);
    pin_vec_t nxt;
    nxt = pin_in;
    nxt[k] = v;
    nxt[23:16] = 8'($random(seed));
    @(posedge core_clk);
    #2;
    pin_in = nxt;
  endtask : pin_set

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    mcu.rd(a, rd_val);
    chk($sformatf("reg_%h", a), e, rd_val);
  endtask : rd_chk

  task automatic chk_int(input logic e);
    idle(6);
    chk("int_oe_n", {7'h00, e}, {7'h00, int_oe_n});
    chk("int_out", 8'h00, {7'h00, int_out});
  endtask : chk_int

  task automatic ticks(input int n);
    repeat (n) begin
      pin_set(0, 1'b1);
      idle(4);
      pin_set(0, 1'b0);
      idle(4);
    end
  endtask : ticks

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    #2;
    reset = 1'b0;
    idle(4);
    rd_chk(8'h76, 8'h00);
    rd_chk(8'h54, 8'hFF);
    rd_chk(8'h0C, 8'hFF);
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h80, 8'h00);
    rnd = 8'($random(seed));
    mcu.wr(8'h76, rnd);
    rd_chk(8'h76, rnd);
    mcu.wr(8'h76, 8'h00);
    chk_int(1'b1);
    mcu.wr(8'h54, 8'hDF);
    pin_set(5, 1'b1);
    chk_int(1'b0);
    pin_set(5, 1'b0);
    chk_int(1'b1);
    for (int m = 0; m < 4; m++) begin
      mcu.wr(8'h61, 8'(m << 2));
      mcu.rd(8'h00, rd_val);
      for (int v = 1; v >= 0; v--) begin
        pin_set(5, v[0]);
        chk_int(~hit(m, 1 - v, v));
        rd_chk(8'h00, 8'(v << 5));
        chk_int(1'b1);
      end
    end
    mcu.wr(8'h61, 8'h00);
    pin_set(5, 1'b1);
    chk_int(1'b0);
    mcu.wr(8'h61, 8'h04);
    chk_int(1'b1);
    pin_set(5, 1'b0);
    pin_set(5, 1'b1);
    chk_int(1'b0);
    mcu.wr(8'h0C, 8'hDF);
    chk_int(1'b1);
    pin_set(5, 1'b0);
    pin_set(5, 1'b1);
    chk_int(1'b1);
    mcu.wr(8'h0C, 8'hFF);
    idle(4);
    mcu.rd(8'h00, rd_val);
    mcu.wr(8'h61, 8'h0C);
    pin_set(5, 1'b0);
    chk_int(1'b0);
    mcu.wr(8'h54, 8'hFF);
    chk_int(1'b1);
    pin_set(5, 1'b1);
    chk_int(1'b1);
    mcu.wr(8'h54, 8'hDF);
    pin_set(5, 1'b0);
    chk_int(1'b0);
    mcu.wr(8'h68, 8'h20);
    chk_int(1'b1);
    rd_chk(8'h68, 8'h00);
    pin_set(5, 1'b1);
    chk_int(1'b0);
    @(posedge core_clk);
    #2;
    sw_reset = 1'b1;
    @(posedge core_clk);
    #2;
    sw_reset = 1'b0;
    chk_int(1'b1);
    rd_chk(8'h54, 8'hFF);
    // Enables first, then the time base, then the count.
    mcu.wr(8'h74, 8'h07);
    ticks(1);
    mcu.wr(8'h76, 8'h03);
    pin_set(1, 1'b1);
    pin_set(2, 1'b1);
    ticks(2);
    rd_chk(8'h6C, 8'h20);
    pin_set(2, 1'b0);
    ticks(1);
    rd_chk(8'h6C, 8'h22);
    mcu.wr(8'h76, 8'h00);
    pin_set(2, 1'b1);
    idle(4);
    rd_chk(8'h6C, 8'h26);
    mcu.wr(8'h76, 8'h03);
    mcu.wr(8'h0C, 8'hFE);
    pin_set(1, 1'b0);
    idle(4);
    mcu.rd(8'h6C, rd_val);
    chk("reg_6c", 8'h24, rd_val & 8'hFE);
    close_out();
  end
endmodule : tb
